// *** logic/prsd_pkg.sv ***
package prsd_pkg;
    localparam logic [11:0] PRST_OFFSET      = 12'h010;
    localparam logic [11:0] SUPV_OFFSET      = 12'h018;
    localparam logic [11:0] UNLOCK_OFFSET    = 12'h100;

    localparam logic [31:0] PRST_RESET       = 32'h0000_0000;
    localparam logic [31:0] PRST_MASK        = 32'h000F_0700;
    localparam int          PRST_PG0_BIT     = 16;
    localparam int          PRST_PG1_BIT     = 17;
    localparam int          PRST_BPG0_BIT    = 18;
    localparam int          PRST_BPG1_BIT    = 19;
    localparam int          PRST_SER3_BIT    = 8;
    localparam int          PRST_SER4_BIT    = 9;
    localparam int          PRST_SER5_BIT    = 10;

    localparam int          SUPV_LVSEL_LSB   = 12;
    localparam int          SUPV_BOSEL_LSB   = 8;
    localparam int          SUPV_LVREN_BIT   = 7;
    localparam int          SUPV_BOOUT_BIT   = 6;
    localparam int          SUPV_LOWPWR_BIT  = 5;
    localparam int          SUPV_IRQF_BIT    = 4;
    localparam int          SUPV_CFG_LSB     = 0;
    localparam logic [2:0]  SUPV_LVSEL_RESET = 3'h0;
    localparam logic [2:0]  SUPV_BOSEL_RESET = 3'h3;
    localparam logic        SUPV_LVREN_RESET = 1'b1;
    localparam logic        SUPV_LOWPWR_RESET = 1'b0;

    localparam logic [7:0]  UNLOCK_BYTE0     = 8'h59;
    localparam logic [7:0]  UNLOCK_BYTE1     = 8'h16;
    localparam logic [7:0]  UNLOCK_BYTE2     = 8'h88;

    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // Code n (1..7) selects 2 << n cycles: 4, 8 .. 256
    localparam logic [8:0]  DG_BASE_CYCLES   = 9'h002;
    localparam logic [2:0]  DG_CODE_OFF      = 3'h0;

    typedef enum logic [3:0] {
        PRSD_UNLK_IDLE = 4'h1,
        PRSD_UNLK_ONE  = 4'h2,
        PRSD_UNLK_TWO  = 4'h4,
        PRSD_UNLK_OPEN = 4'h8
    } prsd_unlk_t;
endpackage

// *** logic/prsd_deglitch.sv ***
`timescale 1ns/1ns
module prsd_deglitch #(
    parameter int CNT_W = 9
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             din,
    input  wire logic [2:0]       sel,
    input  wire logic             sample_mode,
    input  wire logic             sample_en,
    output logic                  dout
);
    typedef struct packed {
        logic             out;
        logic [CNT_W-1:0] cnt;
    } prsd_dg_t;

    prsd_dg_t   st_reg;
    prsd_dg_t   st_next;
    logic [CNT_W-1:0] len;

    // The longest code needs a count of 256
    if (CNT_W < 9) begin : g_cnt_w_check
        $error("prsd_deglitch: CNT_W must hold 256");
    end

    assign len  = CNT_W'(prsd_pkg::DG_BASE_CYCLES << sel);
    assign dout = st_reg.out;

    always_comb begin
        st_next = st_reg;
        if (sel == prsd_pkg::DG_CODE_OFF) begin
            st_next.cnt = '0;
            if (!sample_mode || sample_en) begin
                st_next.out = din;
            end
        end else if (din == st_reg.out) begin
            st_next.cnt = '0; // R12
        end else if (st_reg.cnt + 1'b1 >= len) begin
            st_next.out = din; // R12
            st_next.cnt = '0;
        end else begin
            st_next.cnt = CNT_W'(st_reg.cnt + 1'b1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule // prsd_deglitch

// *** logic/prsd_top.sv ***
`timescale 1ns/1ns
// Contract
// (R1) Writing one to a peripheral reset bit drives a reset into the matching controller.
// (R2) Software writes zero to release a controller; the bit never clears itself.
// (R3) Bits 19 and 18 reset basic pulse generators 1 and 0, bits 17 and 16 pulse generators 1 and 0.
// (R4) Bits 10, 9 and 8 reset serial controllers 5, 4 and 3; zero is normal operation.
// (R5) The peripheral reset register is at 0x10, resets to zero, other bits reserved.
// (R6) Protected supervisor fields accept writes only after 59h, 16h, 88h go to the unlock register.
// (R7) The supervisor register resets to 0x38X with its low nibble from the flash configuration.
// (R8) Low-voltage filter code 000 passes directly, 001 to 111 need 4 to 256 stable cycles.
// (R9) Brown-out filter code 000 samples on the slow RC clock, 001 to 110 need 4 to 128 cycles.
// (R10) Brown-out filter code 111 needs 256 stable cycles.
// (R11) The low-voltage reset enable is set after reset.
// (R12) A filter passes a change only after the level holds for the chosen count, restarting on a toggle.
module prsd_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [3:0]  flash_cfg_nibble,
    input  wire logic        low_voltage_detect,
    input  wire logic        brownout_detect,
    input  wire logic        slow_rc_clock,
    output logic             basic_pulse_gen1_reset,
    output logic             basic_pulse_gen0_reset,
    output logic             pulse_gen1_reset,
    output logic             pulse_gen0_reset,
    output logic             serial5_reset,
    output logic             serial4_reset,
    output logic             serial3_reset,
    output logic             low_voltage_filtered,
    output logic             low_voltage_reset_request,
    output logic             brownout_detector_output,
    output logic             brownout_low_power,
    output logic [3:0]       brownout_cfg_bits,
    output logic             write_protect_unlock
);
    typedef struct packed {
        logic                  aw_have;
        logic [11:0]           aw_addr;
        logic                  w_have;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic [31:0]           prst;
        logic [2:0]            lv_sel;
        logic [2:0]            bo_sel;
        logic                  low_voltage_reset_enable;
        logic                  low_pwr;
        logic [3:0]            cfg;
        logic                  cfg_load;
        prsd_pkg::prsd_unlk_t  unlk;
        logic [1:0]            lv_sync;
        logic [1:0]            bo_sync;
        logic [1:0]            rc_sync;
        logic                  rc_prev;
    } prsd_state_t;

    prsd_state_t st_reg;
    prsd_state_t st_next;
    logic        lv_filt;
    logic        bo_filt;
    logic        rc_rise;
    logic        wr_fire;
    logic        unlocked;
    logic [31:0] supv_word;
    logic [31:0] wmask;
    logic [7:0]  wbyte;

    assign unlocked = (st_reg.unlk == prsd_pkg::PRSD_UNLK_OPEN);
    assign rc_rise  = st_reg.rc_sync[1] && !st_reg.rc_prev;
    assign wr_fire  = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
    assign wbyte    = st_reg.w_strb[0] ? st_reg.w_data[7:0] : 8'h00;

    always_comb begin
        wmask = '0;
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{st_reg.w_strb[i]}};
        end
    end

    always_comb begin
        supv_word = '0;
        supv_word[prsd_pkg::SUPV_LVSEL_LSB +: 3] = st_reg.lv_sel;
        supv_word[prsd_pkg::SUPV_BOSEL_LSB +: 3] = st_reg.bo_sel;
        supv_word[prsd_pkg::SUPV_LVREN_BIT]      = st_reg.low_voltage_reset_enable;
        supv_word[prsd_pkg::SUPV_BOOUT_BIT]      = bo_filt;
        supv_word[prsd_pkg::SUPV_LOWPWR_BIT]     = st_reg.low_pwr;
        supv_word[prsd_pkg::SUPV_CFG_LSB +: 4]   = st_reg.cfg;
    end

    // Stage 0 of each synchroniser is read only by its stage 1
    prsd_deglitch #(
        .CNT_W       (9)
    ) u_lv_filter (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .din         (st_reg.lv_sync[1]),
        .sel         (st_reg.lv_sel),
        .sample_mode (1'b0),
        .sample_en   (1'b0),
        .dout        (lv_filt)
    ); // R8 R12

    prsd_deglitch #(
        .CNT_W       (9)
    ) u_bo_filter (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .din         (st_reg.bo_sync[1]),
        .sel         (st_reg.bo_sel),
        .sample_mode (1'b1),
        .sample_en   (rc_rise),
        .dout        (bo_filt)
    ); // R9 R10 R12

    always_comb begin
        st_next = st_reg;
        st_next.lv_sync = {st_reg.lv_sync[0], low_voltage_detect};
        st_next.bo_sync = {st_reg.bo_sync[0], brownout_detect};
        st_next.rc_sync = {st_reg.rc_sync[0], slow_rc_clock};
        st_next.rc_prev = st_reg.rc_sync[1];

        // Flash configuration is caught on the first edge after release
        if (st_reg.cfg_load) begin
            st_next.cfg      = flash_cfg_nibble; // R7
            st_next.cfg_load = 1'b0;
        end

        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_have = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_have = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end

        if (wr_fire) begin
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = prsd_pkg::RESP_OKAY;
            case ({st_reg.aw_addr[11:2], 2'b00})
                prsd_pkg::PRST_OFFSET: begin
                    // Bits hold until software writes zero back
                    st_next.prst = ((st_reg.prst & ~wmask) | (st_reg.w_data & wmask))
                                   & prsd_pkg::PRST_MASK; // R1 R2 R5
                end
                prsd_pkg::SUPV_OFFSET: begin
                    if (unlocked) begin
                        if (st_reg.w_strb[1]) begin
                            st_next.lv_sel = st_reg.w_data[prsd_pkg::SUPV_LVSEL_LSB +: 3]; // R6
                            st_next.bo_sel = st_reg.w_data[prsd_pkg::SUPV_BOSEL_LSB +: 3]; // R6
                        end
                        if (st_reg.w_strb[0]) begin
                            st_next.low_voltage_reset_enable  = st_reg.w_data[prsd_pkg::SUPV_LVREN_BIT]; // R6
                            st_next.low_pwr = st_reg.w_data[prsd_pkg::SUPV_LOWPWR_BIT];
                            st_next.cfg     = st_reg.w_data[prsd_pkg::SUPV_CFG_LSB +: 4];
                        end
                    end
                end
                prsd_pkg::UNLOCK_OFFSET: begin
                    // Any byte out of sequence, or any write once open, locks again
                    case (st_reg.unlk)
                        prsd_pkg::PRSD_UNLK_IDLE: begin
                            st_next.unlk = (wbyte == prsd_pkg::UNLOCK_BYTE0) ? prsd_pkg::PRSD_UNLK_ONE
                                                                             : prsd_pkg::PRSD_UNLK_IDLE; // R6
                        end
                        prsd_pkg::PRSD_UNLK_ONE: begin
                            st_next.unlk = (wbyte == prsd_pkg::UNLOCK_BYTE1) ? prsd_pkg::PRSD_UNLK_TWO
                                                                             : prsd_pkg::PRSD_UNLK_IDLE; // R6
                        end
                        prsd_pkg::PRSD_UNLK_TWO: begin
                            st_next.unlk = (wbyte == prsd_pkg::UNLOCK_BYTE2) ? prsd_pkg::PRSD_UNLK_OPEN
                                                                             : prsd_pkg::PRSD_UNLK_IDLE; // R6
                        end
                        default: begin
                            st_next.unlk = prsd_pkg::PRSD_UNLK_IDLE;
                        end
                    endcase
                end
                default: begin
                    st_next.bresp = prsd_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = prsd_pkg::RESP_OKAY;
            case ({s_axi_araddr[11:2], 2'b00})
                prsd_pkg::PRST_OFFSET: begin
                    st_next.rdata = st_reg.prst;
                end
                prsd_pkg::SUPV_OFFSET: begin
                    st_next.rdata = supv_word;
                end
                prsd_pkg::UNLOCK_OFFSET: begin
                    st_next.rdata = {31'h0000_0000, unlocked};
                end
                default: begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.rresp = prsd_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg          <= '0;
            st_reg.prst     <= prsd_pkg::PRST_RESET; // R5
            st_reg.lv_sel   <= prsd_pkg::SUPV_LVSEL_RESET; // R7
            st_reg.bo_sel   <= prsd_pkg::SUPV_BOSEL_RESET; // R7
            st_reg.low_voltage_reset_enable   <= prsd_pkg::SUPV_LVREN_RESET; // R11
            st_reg.low_pwr  <= prsd_pkg::SUPV_LOWPWR_RESET;
            st_reg.cfg_load <= 1'b1;
            st_reg.unlk     <= prsd_pkg::PRSD_UNLK_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = !st_reg.aw_have && !st_reg.bvalid;
    assign s_axi_wready  = !st_reg.w_have && !st_reg.bvalid;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;

    // Register bits drive the controller resets directly, so release is asynchronous to them
    assign basic_pulse_gen1_reset = st_reg.prst[prsd_pkg::PRST_BPG1_BIT]; // R1 R3
    assign basic_pulse_gen0_reset = st_reg.prst[prsd_pkg::PRST_BPG0_BIT]; // R3
    assign pulse_gen1_reset       = st_reg.prst[prsd_pkg::PRST_PG1_BIT]; // R3
    assign pulse_gen0_reset       = st_reg.prst[prsd_pkg::PRST_PG0_BIT]; // R3
    assign serial5_reset          = st_reg.prst[prsd_pkg::PRST_SER5_BIT]; // R4
    assign serial4_reset          = st_reg.prst[prsd_pkg::PRST_SER4_BIT]; // R4
    assign serial3_reset          = st_reg.prst[prsd_pkg::PRST_SER3_BIT]; // R4

    assign low_voltage_filtered      = lv_filt;
    assign low_voltage_reset_request = lv_filt && st_reg.low_voltage_reset_enable; // R11
    assign brownout_detector_output  = bo_filt;
    assign brownout_low_power        = st_reg.low_pwr;
    assign brownout_cfg_bits         = st_reg.cfg;
    assign write_protect_unlock      = unlocked;
endmodule // prsd_top

// *** testbench/prsd_top_asserts.sv ***
`timescale 1ns/1ns
module prsd_top_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        low_voltage_detect,
    input wire logic        basic_pulse_gen1_reset,
    input wire logic        basic_pulse_gen0_reset,
    input wire logic        pulse_gen1_reset,
    input wire logic        pulse_gen0_reset,
    input wire logic        serial5_reset,
    input wire logic        serial4_reset,
    input wire logic        serial3_reset,
    input wire logic        low_voltage_filtered,
    input wire logic        low_voltage_reset_request,
    input wire logic [3:0]  brownout_cfg_bits,
    input wire logic        write_protect_unlock
);
    logic [11:0] rd_addr_reg;
    wire  [6:0]  rst_bits = {basic_pulse_gen1_reset, basic_pulse_gen0_reset, pulse_gen1_reset,
                             pulse_gen0_reset, serial5_reset, serial4_reset, serial3_reset};
    wire         rd_ok    = s_axi_rvalid && s_axi_rresp == prsd_pkg::RESP_OKAY;
    wire         prst_rd  = rd_ok && rd_addr_reg == prsd_pkg::PRST_OFFSET;
    wire         supv_rd  = rd_ok && rd_addr_reg == prsd_pkg::SUPV_OFFSET;

    // Read answers are judged against the address taken, not the one now on the bus
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_reg <= s_axi_araddr;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_rst_change; $changed(rst_bits) |-> $rose(s_axi_bvalid); endproperty
    a_rst_change: assert property (p_rst_change) else $error("reset output moved without a write");
    property p_map_pg; prst_rd |-> s_axi_rdata[19:16] == rst_bits[6:3]; endproperty
    a_map_pg: assert property (p_map_pg) else $error("pulse reset outputs differ from bits 19..16");
    property p_map_ser; prst_rd |-> s_axi_rdata[10:8] == rst_bits[2:0]; endproperty
    a_map_ser: assert property (p_map_ser) else $error("serial reset outputs differ from bits 10..8");
    property p_resv; prst_rd |-> (s_axi_rdata & ~prsd_pkg::PRST_MASK) == 32'h0000_0000; endproperty
    a_resv: assert property (p_resv) else $error("reserved reset bits read nonzero");
    property p_unlock; $rose(write_protect_unlock) |-> $rose(s_axi_bvalid); endproperty
    a_unlock: assert property (p_unlock) else $error("unlock without a write");
    property p_cfg; supv_rd |-> s_axi_rdata[3:0] == brownout_cfg_bits; endproperty
    a_cfg: assert property (p_cfg) else $error("config bits differ from read");
    property p_lvr_req; low_voltage_reset_request |-> low_voltage_filtered; endproperty
    a_lvr_req: assert property (p_lvr_req) else $error("reset request without low voltage");
    property p_lv_filter; $rose(low_voltage_filtered) |-> $past(low_voltage_detect, 2); endproperty
    a_lv_filter: assert property (p_lv_filter) else $error("filter passed an absent level");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped early");
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");

    c_prst_rd: cover property (prst_rd);
    c_unlock: cover property ($rose(write_protect_unlock));
    c_filter: cover property ($rose(low_voltage_filtered));
endmodule // prsd_top_asserts

bind prsd_top prsd_top_asserts prsd_top_asserts_inst (.*);

// *** testbench/prsd_top_tb_top.sv ***
`timescale 1ns/1ns
module prsd_top_tb_top;
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, low_voltage_detect = 0, brownout_detect = 0;
    logic        slow_rc_clock = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0]  s_axi_wstrb = 4'hF, flash_cfg_nibble = 4'hA;
    logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        basic_pulse_gen1_reset, basic_pulse_gen0_reset, pulse_gen1_reset, pulse_gen0_reset;
    logic        serial5_reset, serial4_reset, serial3_reset, low_voltage_filtered;
    logic        low_voltage_reset_request, brownout_detector_output, brownout_low_power;
    logic        write_protect_unlock;
    logic [3:0]  brownout_cfg_bits;
    int          errors = 0, check_count = 0, cyc = 0, n;
    int          pos [7] = '{19, 18, 17, 16, 10, 9, 8};
    wire  [6:0]  rst_bits = {basic_pulse_gen1_reset, basic_pulse_gen0_reset, pulse_gen1_reset,
                             pulse_gen0_reset, serial5_reset, serial4_reset, serial3_reset};

    prsd_top prsd_top_inst (.*);

    always #2 aclk = ~aclk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Long enough for the 256-cycle filter and every bus access with margin
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // A leading edge keeps a second call from reassigning bready or rready in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, resp);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, resp);
        chk(s_axi_rdata, d);
    endtask

    // Any unlock-register write while open relocks, so start from a known locked state
    task automatic unlock();
        wr(prsd_pkg::UNLOCK_OFFSET, 32'h0000_0000, prsd_pkg::RESP_OKAY);
        chk(write_protect_unlock, 32'h0);
        wr(prsd_pkg::UNLOCK_OFFSET, 32'h0000_0059, prsd_pkg::RESP_OKAY);
        wr(prsd_pkg::UNLOCK_OFFSET, 32'h0000_0016, prsd_pkg::RESP_OKAY);
        wr(prsd_pkg::UNLOCK_OFFSET, 32'h0000_0088, prsd_pkg::RESP_OKAY);
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(12'h010, 32'h0000_0000, prsd_pkg::RESP_OKAY);
        rd(12'h018, 32'h0000_038A, prsd_pkg::RESP_OKAY);
        chk(brownout_cfg_bits, 32'hA);
        wr(12'h010, 32'hFFFF_FFFF, prsd_pkg::RESP_OKAY);
        rd(12'h010, 32'h000F_0700, prsd_pkg::RESP_OKAY);
        chk(rst_bits, 32'h7F);
        for (int i = 0; i < 7; i++) begin
            wr(12'h010, 32'h1 << pos[i], prsd_pkg::RESP_OKAY);
            repeat (20) @(posedge aclk);
            chk(rst_bits, 32'h1 << (6 - i));
        end
        wr(12'h010, 32'h0000_0000, prsd_pkg::RESP_OKAY);
        chk(rst_bits, 32'h0);
        rd(12'h020, 32'h0000_0000, prsd_pkg::RESP_SLVERR);
        wr(12'h018, 32'h0000_717A, prsd_pkg::RESP_OKAY);
        rd(12'h018, 32'h0000_038A, prsd_pkg::RESP_OKAY);
        wr(prsd_pkg::UNLOCK_OFFSET, 32'h0000_0059, prsd_pkg::RESP_OKAY);
        wr(prsd_pkg::UNLOCK_OFFSET, 32'h0000_0088, prsd_pkg::RESP_OKAY);
        chk(write_protect_unlock, 32'h0);
        unlock();
        chk(write_protect_unlock, 32'h1);
        wr(12'h018, 32'h0000_118A, prsd_pkg::RESP_OKAY);
        rd(12'h018, 32'h0000_118A, prsd_pkg::RESP_OKAY);
        // Three-cycle pulse is shorter than the four-cycle filter and must vanish
        low_voltage_detect <= 1'b1;
        repeat (3) @(posedge aclk);
        low_voltage_detect <= 1'b0;
        repeat (12) @(posedge aclk);
        chk(low_voltage_filtered, 32'h0);
        low_voltage_detect <= 1'b1;
        n = 0;
        while (!low_voltage_filtered && n < 50) begin
            @(posedge aclk);
            n++;
        end
        chk(n >= 6 && n <= 9, 32'h1);
        chk(low_voltage_reset_request, 32'h1);
        low_voltage_detect <= 1'b0;
        unlock();
        wr(12'h018, 32'h0000_078A, prsd_pkg::RESP_OKAY);
        brownout_detect <= 1'b1;
        n = 0;
        while (!brownout_detector_output && n < 400) begin
            @(posedge aclk);
            n++;
        end
        chk(n >= 258 && n <= 262, 32'h1);
        rd(12'h018, 32'h0000_07CA, prsd_pkg::RESP_OKAY);
        low_voltage_detect <= 1'b1;
        repeat (5) @(posedge aclk);
        chk(low_voltage_filtered, 32'h1);
        // Code 000 holds the brown-out level until a slow clock rising edge
        unlock();
        wr(12'h018, 32'h0000_008A, prsd_pkg::RESP_OKAY);
        brownout_detect <= 1'b0;
        repeat (10) @(posedge aclk);
        chk(brownout_detector_output, 32'h1);
        slow_rc_clock <= 1'b1;
        repeat (8) @(posedge aclk);
        chk(brownout_detector_output, 32'h0);
        unlock();
        wr(12'h018, 32'h0000_072A, prsd_pkg::RESP_OKAY);
        chk(low_voltage_reset_request, 32'h0);
        chk(brownout_low_power, 32'h1);
        print_verdict();
    end
endmodule // prsd_top_tb_top
